// ==== hw/i2c_flags_pkg.sv ====
// Purpose: constants for the low interrupt flag block
// Assumes: APB, 32-bit data, one aligned word per register
// Notes: flag and enable registers share one bit layout
// Functional notes
// - controller arbitration loss sets bit 8; write one clears; resets low.
// - controller address acknowledge sets bit 7; write one clears.
// - target STOP detection sets bit 6; write one clears, zero ignored.
// - bit 5 follows tx count at or below threshold; resets high.
// - bit 4 follows rx count at or above threshold; resets high.
// - target own address match sets bit 3; write one clears.
// - target general call match sets bit 2; write one clears.
// - interactive receive condition sets bit 1; write one clears.
// - transaction completion sets bit 0 in both modes; write one clears.
// - enable bits at same positions gate flags onto the interrupt.
package i2c_flags_pkg;
  localparam logic [11:0] flags_off = 12'h008;
  localparam logic [11:0] enables_off = 12'h00C;
  localparam int flag_w = 9;
  localparam int bit_arb = 8;
  localparam int bit_addr_ack = 7;
  localparam int bit_stop = 6;
  localparam int bit_tx_lvl = 5;
  localparam int bit_rx_lvl = 4;
  localparam int bit_addr_hit = 3;
  localparam int bit_gc_hit = 2;
  localparam int bit_irx = 1;
  localparam int bit_done = 0;
  localparam logic [8:0] flags_reset = 9'h030;
  localparam logic [8:0] enables_reset = 9'h000;
  localparam logic [8:0] level_mask = 9'h030;
endpackage

// ==== hw/i2c_event_flags.sv ====
// Purpose: low interrupt flag and enable registers over APB
// Assumes: event inputs are one-cycle pulses on pclk; levels are on pclk
// Notes: unmapped addresses read zero, writes ignored, no error
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
module i2c_event_flags (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ctrl_mode,
  input wire logic arb_lost,
  input wire logic addr_acked,
  input wire logic stop_seen,
  input wire logic tx_at_or_below,
  input wire logic rx_at_or_above,
  input wire logic own_addr_match,
  input wire logic gen_call_match,
  input wire logic irx_event,
  input wire logic xfer_done,
  output logic irq
);
  typedef struct packed {
    logic [8:0] flags;
    logic [8:0] enables;
    logic [31:0] rdata;
  } state_t;

  state_t st_reg, st_next;
  logic wr, rd;
  logic [8:0] set_ev, clr;

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;

  always_comb begin
    set_ev = '0;
    set_ev[i2c_flags_pkg::bit_arb] = ctrl_mode && arb_lost;
    set_ev[i2c_flags_pkg::bit_addr_ack] = ctrl_mode && addr_acked;
    set_ev[i2c_flags_pkg::bit_stop] = !ctrl_mode && stop_seen;
    set_ev[i2c_flags_pkg::bit_addr_hit] = !ctrl_mode && own_addr_match;
    set_ev[i2c_flags_pkg::bit_gc_hit] = !ctrl_mode && gen_call_match;
    set_ev[i2c_flags_pkg::bit_irx] = irx_event;
    set_ev[i2c_flags_pkg::bit_done] = xfer_done;
    clr = '0;
    if (wr && paddr == i2c_flags_pkg::flags_off) begin
      clr = pwdata[8:0] & ~i2c_flags_pkg::level_mask;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.flags = (st_reg.flags & ~clr) | set_ev;
    st_next.flags[i2c_flags_pkg::bit_tx_lvl] = tx_at_or_below;
    st_next.flags[i2c_flags_pkg::bit_rx_lvl] = rx_at_or_above;
    if (wr && paddr == i2c_flags_pkg::enables_off) begin
      st_next.enables = pwdata[8:0];
    end
    if (rd) begin
      unique case (paddr)
        i2c_flags_pkg::flags_off: st_next.rdata = {23'h000000, st_reg.flags};
        i2c_flags_pkg::enables_off:
          st_next.rdata = {23'h000000, st_reg.enables};
        default: st_next.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg.flags <= i2c_flags_pkg::flags_reset;
      st_reg.enables <= i2c_flags_pkg::enables_reset;
      st_reg.rdata <= 32'h00000000;
    end else begin
      st_reg <= st_next;
    end
  end

  assign prdata = st_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign irq = |(st_reg.flags & st_reg.enables);

  sequence s_flag_write;
    wr && paddr == i2c_flags_pkg::flags_off;
  endsequence

  sequence s_no_flag_write;
    !(wr && paddr == i2c_flags_pkg::flags_off);
  endsequence

  sequence s_en_write;
    wr && paddr == i2c_flags_pkg::enables_off;
  endsequence

  sequence s_flag_read;
    rd && paddr == i2c_flags_pkg::flags_off;
  endsequence

  sequence s_en_read;
    rd && paddr == i2c_flags_pkg::enables_off;
  endsequence

  sequence s_clear_done;
    s_flag_write ##0 pwdata[i2c_flags_pkg::bit_done];
  endsequence

  sequence s_ctrl_side;
    ctrl_mode;
  endsequence

  sequence s_target_side;
    !ctrl_mode;
  endsequence

  a_arb_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_side ##0 arb_lost
    |=> st_reg.flags[i2c_flags_pkg::bit_arb])
    else $error("arb flag not set");

  a_ack_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_side ##0 addr_acked
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_ack])
    else $error("ack flag not set");

  a_stop_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_target_side ##0 stop_seen
    |=> st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop flag not set");

  a_hit_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_target_side ##0 own_addr_match
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_hit])
    else $error("addr hit not set");

  a_gc_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_target_side ##0 gen_call_match
    |=> st_reg.flags[i2c_flags_pkg::bit_gc_hit])
    else $error("general call not set");

  a_irx_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    irx_event
    |=> st_reg.flags[i2c_flags_pkg::bit_irx])
    else $error("irx flag not set");

  a_done_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    xfer_done
    |=> st_reg.flags[i2c_flags_pkg::bit_done])
    else $error("done flag not set");

  a_arb_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[8] && !set_ev[8]
    |=> !st_reg.flags[i2c_flags_pkg::bit_arb])
    else $error("arb flag not cleared");

  a_ack_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[7] && !set_ev[7]
    |=> !st_reg.flags[i2c_flags_pkg::bit_addr_ack])
    else $error("ack flag not cleared");

  a_stop_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[6] && !set_ev[6]
    |=> !st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop flag not cleared");

  a_hit_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[3] && !set_ev[3]
    |=> !st_reg.flags[i2c_flags_pkg::bit_addr_hit])
    else $error("addr hit not cleared");

  a_gc_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[2] && !set_ev[2]
    |=> !st_reg.flags[i2c_flags_pkg::bit_gc_hit])
    else $error("general call not cleared");

  a_irx_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[1] && !set_ev[1]
    |=> !st_reg.flags[i2c_flags_pkg::bit_irx])
    else $error("irx flag not cleared");

  a_done_clear: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_clear_done ##0 !xfer_done
    |=> !st_reg.flags[i2c_flags_pkg::bit_done])
    else $error("done not cleared");

  a_arb_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[8] && !pwdata[8]
    |=> st_reg.flags[i2c_flags_pkg::bit_arb])
    else $error("arb flag lost on zero");

  a_ack_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[7] && !pwdata[7]
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_ack])
    else $error("ack flag lost on zero");

  a_stop_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[6] && !pwdata[6]
    |=> st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop flag lost on zero");

  a_hit_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[3] && !pwdata[3]
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_hit])
    else $error("addr hit lost on zero");

  a_gc_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[2] && !pwdata[2]
    |=> st_reg.flags[i2c_flags_pkg::bit_gc_hit])
    else $error("general call lost on zero");

  a_irx_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[1] && !pwdata[1]
    |=> st_reg.flags[i2c_flags_pkg::bit_irx])
    else $error("irx flag lost on zero");

  a_done_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 st_reg.flags[0] && !pwdata[0]
    |=> st_reg.flags[i2c_flags_pkg::bit_done])
    else $error("done flag lost on zero");

  a_stop_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_no_flag_write ##0 st_reg.flags[i2c_flags_pkg::bit_stop]
    |=> st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop flag lost");

  a_arb_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[8] && set_ev[8]
    |=> st_reg.flags[i2c_flags_pkg::bit_arb])
    else $error("arb set lost to clear");

  a_ack_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[7] && set_ev[7]
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_ack])
    else $error("ack set lost to clear");

  a_stop_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[6] && set_ev[6]
    |=> st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop set lost to clear");

  a_hit_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[3] && set_ev[3]
    |=> st_reg.flags[i2c_flags_pkg::bit_addr_hit])
    else $error("addr hit set lost to clear");

  a_gc_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[2] && set_ev[2]
    |=> st_reg.flags[i2c_flags_pkg::bit_gc_hit])
    else $error("general call set lost to clear");

  a_irx_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_write ##0 pwdata[1] && set_ev[1]
    |=> st_reg.flags[i2c_flags_pkg::bit_irx])
    else $error("irx set lost to clear");

  a_set_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_clear_done ##0 xfer_done
    |=> st_reg.flags[i2c_flags_pkg::bit_done])
    else $error("set lost to clear");

  a_arb_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_target_side ##0 !st_reg.flags[i2c_flags_pkg::bit_arb]
    |=> !st_reg.flags[i2c_flags_pkg::bit_arb])
    else $error("arb flag set in target mode");

  a_ack_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_target_side ##0 !st_reg.flags[i2c_flags_pkg::bit_addr_ack]
    |=> !st_reg.flags[i2c_flags_pkg::bit_addr_ack])
    else $error("ack flag set in target mode");

  a_stop_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_side ##0 !st_reg.flags[i2c_flags_pkg::bit_stop]
    |=> !st_reg.flags[i2c_flags_pkg::bit_stop])
    else $error("stop flag set in controller mode");

  a_hit_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_side ##0 !st_reg.flags[i2c_flags_pkg::bit_addr_hit]
    |=> !st_reg.flags[i2c_flags_pkg::bit_addr_hit])
    else $error("addr hit set in controller mode");

  a_gc_gated: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_ctrl_side ##0 !st_reg.flags[i2c_flags_pkg::bit_gc_hit]
    |=> !st_reg.flags[i2c_flags_pkg::bit_gc_hit])
    else $error("general call set in controller mode");

  a_tx_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1
    |=> st_reg.flags[i2c_flags_pkg::bit_tx_lvl] == $past(tx_at_or_below))
    else $error("tx level wrong");

  a_rx_level: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1
    |=> st_reg.flags[i2c_flags_pkg::bit_rx_lvl] == $past(rx_at_or_above))
    else $error("rx level wrong");

  a_en_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_en_write
    |=> st_reg.enables == $past(pwdata[8:0]))
    else $error("enable write lost");

  a_flag_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_flag_read
    |=> prdata == {23'h000000, $past(st_reg.flags)})
    else $error("flag read data wrong");

  a_en_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_en_read
    |=> prdata == {23'h000000, $past(st_reg.enables)})
    else $error("enable read data wrong");

  a_irq_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    1'b1
    |-> irq == |(st_reg.flags & st_reg.enables))
    else $error("irq gating wrong");

endmodule

// ==== testbench/bus_events.sv ====
// Purpose: far-side event source for the flag block
// Assumes: one request bit per flag position
// Notes: events pulse one cycle; bits 5 and 4 are levels
`timescale 1ns/1ns
module bus_events (
  input wire logic pclk,
  input wire logic [8:0] req,
  output logic [8:0] ev
);
  always_ff @(posedge pclk) begin
    ev <= req;
  end
endmodule

// ==== testbench/i2c_interrupt_flag_low_bits_tb.sv ====
// Purpose: random and corner tests of the low flag block
// Assumes: zero-wait APB; events reach flags two cycles after request
// Notes: xorshift seed 32'h2AAA
`timescale 1ns/1ns
module i2c_interrupt_flag_low_bits_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic ctrl_mode = 0, pready, pslverr, irq;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, d, s = 32'h2AAA;
  logic [8:0] req = 9'h030, ev;
  int bad_count = 0, compares = 0, cyc = 0, b;
  always #2 pclk = ~pclk;
  bus_events far_u (.pclk(pclk), .req(req), .ev(ev));
  i2c_event_flags dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_mode(ctrl_mode), .arb_lost(ev[8]), .addr_acked(ev[7]),
    .stop_seen(ev[6]), .tx_at_or_below(ev[5]), .rx_at_or_above(ev[4]),
    .own_addr_match(ev[3]), .gen_call_match(ev[2]), .irx_event(ev[1]),
    .xfer_done(ev[0]), .irq(irq));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic logic [31:0] lvl(input logic [8:0] r);
    return {23'h0, r & 9'h030};
  endfunction
  task automatic chk(input logic [31:0] seen, exp, input string nm);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] wd);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    d = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic pulse(input int i);
    req[i] <= 1;
    @(posedge pclk) req[i] <= 0;
    repeat (2) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      bad_count++;
      close_out;
    end
  end
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    apb(0, 12'h008, 0); chk(d, 32'h30, "flags reset");
    apb(0, 12'h00C, 0); chk(d, 0, "enables reset");
    $display("reset test done");
    for (b = 0; b < 9; b++) begin
      if (b == 4 || b == 5) continue;
      s = xs(s);
      ctrl_mode <= (b > 6) | ((b < 2) & s[0]);
      pulse(b);
      apb(0, 12'h008, 0); chk(d[b], 1, "flag set");
      apb(1, 12'h008, s & ~(32'h1 << b));
      apb(0, 12'h008, 0); chk(d[b], 1, "zero write");
      apb(1, 12'h008, 32'h1 << b);
      apb(0, 12'h008, 0); chk(d, 32'h30, "flag clear");
      $display("flag test %0d done", b);
    end
    repeat (8) begin
      s = xs(s);
      req[5:4] <= s[5:4];
      repeat (3) @(posedge pclk);
      apb(1, 12'h008, 32'h30);
      apb(0, 12'h008, 0); chk(d, lvl(s[8:0]), "levels");
    end
    $display("level test done");
    apb(1, 12'h00C, 32'h1);
    pulse(0);
    chk(irq, 1, "irq");
    apb(1, 12'h00C, 32'h1CE); chk(irq, 0, "irq masked");
    apb(1, 12'h008, 32'h1);
    apb(1, 12'h00C, 32'h1); chk(irq, 0, "irq cleared");
    req[0] <= 1;
    fork
      apb(1, 12'h008, 32'h1);
      begin
        @(posedge pclk) req[0] <= 0;
      end
    join
    apb(0, 12'h008, 0); chk(d[0], 1, "set wins");
    apb(1, 12'h008, 32'h1);
    apb(0, 12'h008, 0); chk(d[0], 0, "clear after win");
    apb(0, 12'h010, 0); chk(d, 0, "unmapped");
    $display("irq test done");
    close_out;
  end
endmodule
